//--- eeprom_front_pkg.sv
// Shared constants and types for the two-wire memory front end
package eeprom_front_pkg;

  // Byte and address geometry
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 13;
  localparam int PAGE_BITS = 5;
  localparam int ADDR_HI_W = ADDR_W - BYTE_W;
  localparam int TYPE_W = 4;
  localparam int CS_W = 3;

  // Control byte field positions
  localparam int CTRL_RW_POS = 0;
  localparam int CTRL_CS_LSB = 1;
  localparam int CTRL_TYPE_LSB = 4;

  // Bit counter marks within one byte frame
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_DONE = 4'h9;

  // Synchroniser lanes for outside inputs
  localparam int SYNC_W = 6;
  localparam int SYNC_SCL = 0;
  localparam int SYNC_SDA = 1;
  localparam int SYNC_WP = 2;
  localparam int SYNC_CS0 = 3;

  // Write path buffer
  localparam int FIFO_DEPTH = 16;

  // Self-timed write cycle
  localparam int CLK_MHZ = 100;
  localparam int TWC_MS = 5;
  localparam int TWC_CYCLES = TWC_MS * 1000 * CLK_MHZ;
  localparam int BUSY_W = 20;

  // Reset values
  localparam logic [ADDR_W-1:0] PTR_RESET = 13'h0000;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 6'h03;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_CTRL,
    PH_ADDR_HI,
    PH_ADDR_LO,
    PH_WDATA,
    PH_RDATA,
    PH_IGNORE
  } phase_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [BYTE_W-1:0] data;
  } wr_beat_s;

  localparam int BEAT_W = ADDR_W + BYTE_W;

  typedef struct packed {
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic prev_scl;
    logic prev_sda;
    phase_e phase;
    logic [3:0] bit_cnt;
    logic [BYTE_W-1:0] shreg;
    logic [BYTE_W-1:0] tx;
    logic drive_low;
    logic rd_wr;
    logic mack;
    logic [ADDR_HI_W-1:0] addr_hi;
    logic [ADDR_W-1:0] ptr;
    logic wrote;
    logic commit_pend;
    logic [BUSY_W-1:0] busy_cnt;
    logic commit_pulse;
    logic discard_pulse;
  } front_state_s;

endpackage

//--- beat_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module beat_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wr;
    logic [AW:0] rd;
  } fifo_state_s;

  fifo_state_s st_reg;
  fifo_state_s st_next;
  logic full;
  logic empty;

  // Extra pointer bit tells full from empty
  assign empty = st_reg.wr == st_reg.rd;
  assign full = (st_reg.wr[AW] != st_reg.rd[AW]) &&
                (st_reg.wr[AW-1:0] == st_reg.rd[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = st_reg.mem[st_reg.rd[AW-1:0]];

  always_comb begin
    st_next = st_reg;
    if (in_valid && !full) begin
      st_next.mem[st_reg.wr[AW-1:0]] = in_data;
      st_next.wr = st_reg.wr + 1'b1;
    end
    if (out_ready && !empty) begin
      st_next.rd = st_reg.rd + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule
`default_nettype wire

//--- eeprom_front.sv
// Slave front end of a two-wire serial memory: framing, addressing, acks
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Data line moves only while clock is low, except framing.
// - Start is data falling while clock is high.
// - Stop is data rising while clock is high.
// - Bus idle means both lines high; transfers begin only then.
// - One clock pulse per bit; data stable through the high phase.
// - Overlong writes keep only the latest thirty-two bytes.
// - Addressed receiver acknowledges each byte on a ninth clock; the code refuses a data byte while the write buffer is full.
// - No acknowledge at all while a programming cycle runs.
// - Acknowledger holds data low through the ack clock high phase.
// - Master withholds ack on last read byte; device releases line.
// - First byte after Start is control byte with four-bit type code.
// - Chip-select bits must equal the three strap levels.
// - Control byte bit 0 selects read when 1, write when 0.
// - Write takes two address bytes, high first, thirteen bits kept.
// - On full match, ack the control byte and enter read or write.
// - Write-protect high blocks memory writes; reads unaffected.
// - Self-timed write cycle completes within 5 ms after Stop; the code starts its 5 ms count only once the buffer has drained.
// - Write-protect sampled at Stop; later changes ignored.
// - Write data advances only the five low pointer bits.
module eeprom_front #(
  // Arbitrary type code; tie to the system's chosen value
  parameter logic [3:0] DEVICE_TYPE_CODE = 4'h6,
  parameter int unsigned WRITE_CYCLE_CYCLES = eeprom_front_pkg::TWC_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Two-wire pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Straps
  input wire logic chip_select_strap_bit0,
  input wire logic chip_select_strap_bit1,
  input wire logic chip_select_strap_bit2,
  input wire logic write_protect,
  // Write path to page buffer
  output logic wr_valid,
  input wire logic wr_ready,
  output eeprom_front_pkg::wr_beat_s wr_beat,
  output logic write_commit,
  output logic write_discard,
  // Read path from array
  output logic [eeprom_front_pkg::ADDR_W-1:0] rd_addr,
  input wire logic [eeprom_front_pkg::BYTE_W-1:0] rd_data,
  // Status
  output logic program_busy
);

  eeprom_front_pkg::front_state_s st_reg;
  eeprom_front_pkg::front_state_s st_next;

  logic [eeprom_front_pkg::SYNC_W-1:0] raw_in;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic busy;
  logic push;
  eeprom_front_pkg::wr_beat_s push_beat;
  logic fifo_ready;
  logic [eeprom_front_pkg::BEAT_W-1:0] fifo_out;

  // Advance only the page offset bits
  function automatic logic [eeprom_front_pkg::ADDR_W-1:0] page_inc(
    input logic [eeprom_front_pkg::ADDR_W-1:0] p
  );
    logic [eeprom_front_pkg::PAGE_BITS-1:0] low;
    low = p[eeprom_front_pkg::PAGE_BITS-1:0] + 1'b1;
    page_inc = {p[eeprom_front_pkg::ADDR_W-1:eeprom_front_pkg::PAGE_BITS], low};
  endfunction

  // Whole-array increment, rolls over at the top
  function automatic logic [eeprom_front_pkg::ADDR_W-1:0] full_inc(
    input logic [eeprom_front_pkg::ADDR_W-1:0] p
  );
    full_inc = p + 1'b1;
  endfunction

  // Type code and chip select against the caught straps
  function automatic logic ctrl_match(
    input logic [eeprom_front_pkg::BYTE_W-1:0] b,
    input logic [eeprom_front_pkg::CS_W-1:0] straps
  );
    logic type_ok;
    logic cs_ok;
    type_ok = b[eeprom_front_pkg::CTRL_TYPE_LSB +: eeprom_front_pkg::TYPE_W]
              == DEVICE_TYPE_CODE;
    cs_ok = b[eeprom_front_pkg::CTRL_CS_LSB +: eeprom_front_pkg::CS_W]
            == straps;
    ctrl_match = type_ok && cs_ok;
  endfunction

  // Open-drain: a zero bit pulls low, a one releases
  function automatic logic pull_for(input logic bit_val);
    pull_for = !bit_val;
  endfunction

  assign raw_in = {chip_select_strap_bit2, chip_select_strap_bit1,
                   chip_select_strap_bit0, write_protect, sda_in, scl_in};

  // Second stage only; the first stage feeds nothing else
  assign scl = st_reg.sync2[eeprom_front_pkg::SYNC_SCL];
  assign sda = st_reg.sync2[eeprom_front_pkg::SYNC_SDA];
  assign scl_rise = scl && !st_reg.prev_scl;
  assign scl_fall = !scl && st_reg.prev_scl;
  // Data moving while clock stays high is framing, never data
  assign start_det = scl && st_reg.prev_scl && st_reg.prev_sda && !sda;
  assign stop_det = scl && st_reg.prev_scl && !st_reg.prev_sda && sda;

  // Pending commit counts as busy so polling sees no gap
  assign busy = (st_reg.busy_cnt != '0) || st_reg.commit_pend;

  assign sda_out = 1'b0;
  assign sda_oe = st_reg.drive_low;
  assign rd_addr = st_reg.ptr;
  assign write_commit = st_reg.commit_pulse;
  assign write_discard = st_reg.discard_pulse;
  assign program_busy = busy;
  assign wr_beat = eeprom_front_pkg::wr_beat_s'(fifo_out);

  always_comb begin
    logic [eeprom_front_pkg::CS_W-1:0] straps;
    logic [eeprom_front_pkg::BYTE_W-1:0] byte_in;
    straps = st_reg.sync2[eeprom_front_pkg::SYNC_CS0 +: eeprom_front_pkg::CS_W];
    byte_in = st_reg.shreg;
    st_next = st_reg;
    push = 1'b0;
    push_beat = '0;
    st_next.commit_pulse = 1'b0;
    st_next.discard_pulse = 1'b0;

    // Two-flop synchronisers, then one sample for edge finding
    st_next.sync1 = raw_in;
    st_next.sync2 = st_reg.sync1;
    st_next.prev_scl = scl;
    st_next.prev_sda = sda;

    // Self-timed write cycle
    if (st_reg.busy_cnt != '0) begin
      st_next.busy_cnt = st_reg.busy_cnt - 1'b1;
    end
    // Commit only once every beat has left the buffer
    if (st_reg.commit_pend && !wr_valid) begin
      st_next.commit_pend = 1'b0;
      st_next.commit_pulse = 1'b1;
      st_next.busy_cnt = WRITE_CYCLE_CYCLES[eeprom_front_pkg::BUSY_W-1:0];
    end

    if (start_det) begin
      // Partial byte is dropped; unfinished write data is thrown away
      st_next.phase = eeprom_front_pkg::PH_CTRL;
      st_next.bit_cnt = '0;
      st_next.drive_low = 1'b0;
      st_next.wrote = 1'b0;
      st_next.discard_pulse = st_reg.wrote;
    end else if (stop_det) begin
      // Bytes taken before a refused one still get their write cycle
      if (st_reg.wrote) begin
        // Protect level caught here and nowhere else
        if (st_reg.sync2[eeprom_front_pkg::SYNC_WP]) begin
          st_next.discard_pulse = 1'b1;
        end else begin
          st_next.commit_pend = 1'b1;
        end
      end
      st_next.phase = eeprom_front_pkg::PH_IDLE;
      st_next.bit_cnt = '0;
      st_next.drive_low = 1'b0;
      st_next.wrote = 1'b0;
    end else if (st_reg.phase != eeprom_front_pkg::PH_IDLE &&
                 st_reg.phase != eeprom_front_pkg::PH_IGNORE) begin
      if (scl_rise) begin
        // Sample at the rising edge, mid high phase for the line
        if (st_reg.bit_cnt < eeprom_front_pkg::BIT_ACK) begin
          st_next.shreg = {st_reg.shreg[eeprom_front_pkg::BYTE_W-2:0], sda};
        end
        if (st_reg.bit_cnt == eeprom_front_pkg::BIT_ACK) begin
          st_next.mack = !sda;
        end
        if (st_reg.bit_cnt < eeprom_front_pkg::BIT_DONE) begin
          st_next.bit_cnt = st_reg.bit_cnt + 1'b1;
        end
      end else if (scl_fall) begin
        // Every change of our drive happens here, with the clock low
        if (st_reg.bit_cnt == eeprom_front_pkg::BIT_ACK) begin
          case (st_reg.phase)
            eeprom_front_pkg::PH_CTRL: begin
              if (ctrl_match(byte_in, straps) && !busy) begin
                st_next.drive_low = 1'b1;
                st_next.rd_wr = byte_in[eeprom_front_pkg::CTRL_RW_POS];
              end else begin
                st_next.drive_low = 1'b0;
                st_next.phase = eeprom_front_pkg::PH_IGNORE;
              end
            end
            eeprom_front_pkg::PH_ADDR_HI: begin
              // Upper three bits are don't care
              st_next.addr_hi = byte_in[eeprom_front_pkg::ADDR_HI_W-1:0];
              st_next.drive_low = 1'b1;
            end
            eeprom_front_pkg::PH_ADDR_LO: begin
              st_next.ptr = {st_reg.addr_hi, byte_in};
              st_next.drive_low = 1'b1;
            end
            eeprom_front_pkg::PH_WDATA: begin
              // A full buffer cannot take the byte, so it is refused
              if (fifo_ready) begin
                push = 1'b1;
                push_beat.addr = st_reg.ptr;
                push_beat.data = byte_in;
                // Page offset wraps, so later bytes overwrite earlier ones
                st_next.ptr = page_inc(st_reg.ptr);
                st_next.wrote = 1'b1;
                st_next.drive_low = 1'b1;
              end else begin
                st_next.drive_low = 1'b0;
                st_next.phase = eeprom_front_pkg::PH_IGNORE;
              end
            end
            eeprom_front_pkg::PH_RDATA: begin
              // Hand the ack slot to the master
              st_next.drive_low = 1'b0;
            end
            default: begin
              st_next.drive_low = 1'b0;
            end
          endcase
        end else if (st_reg.bit_cnt == eeprom_front_pkg::BIT_DONE) begin
          // Ack held through the whole high phase ends only now
          st_next.drive_low = 1'b0;
          st_next.bit_cnt = '0;
          case (st_reg.phase)
            eeprom_front_pkg::PH_CTRL: begin
              if (st_reg.rd_wr) begin
                st_next.phase = eeprom_front_pkg::PH_RDATA;
                st_next.tx = rd_data;
                st_next.drive_low = pull_for(rd_data[eeprom_front_pkg::BYTE_W-1]);
                st_next.ptr = full_inc(st_reg.ptr);
              end else begin
                st_next.phase = eeprom_front_pkg::PH_ADDR_HI;
              end
            end
            eeprom_front_pkg::PH_ADDR_HI: begin
              st_next.phase = eeprom_front_pkg::PH_ADDR_LO;
            end
            eeprom_front_pkg::PH_ADDR_LO: begin
              st_next.phase = eeprom_front_pkg::PH_WDATA;
            end
            eeprom_front_pkg::PH_WDATA: begin
              st_next.phase = eeprom_front_pkg::PH_WDATA;
            end
            eeprom_front_pkg::PH_RDATA: begin
              if (st_reg.mack) begin
                st_next.tx = rd_data;
                st_next.drive_low = pull_for(rd_data[eeprom_front_pkg::BYTE_W-1]);
                st_next.ptr = full_inc(st_reg.ptr);
              end else begin
                // Line left high so the master can Stop
                st_next.phase = eeprom_front_pkg::PH_IGNORE;
              end
            end
            default: begin
              st_next.phase = eeprom_front_pkg::PH_IGNORE;
            end
          endcase
        end else if (st_reg.phase == eeprom_front_pkg::PH_RDATA) begin
          // Next data bit out, one bit per clock pulse
          st_next.tx = {st_reg.tx[eeprom_front_pkg::BYTE_W-2:0], 1'b0};
          st_next.drive_low = pull_for(st_reg.tx[eeprom_front_pkg::BYTE_W-2]);
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_reg <= '0;
      st_reg.sync1 <= eeprom_front_pkg::SYNC_RESET;
      st_reg.sync2 <= eeprom_front_pkg::SYNC_RESET;
      st_reg.prev_scl <= 1'b1;
      st_reg.prev_sda <= 1'b1;
      st_reg.phase <= eeprom_front_pkg::PH_IDLE;
      st_reg.ptr <= eeprom_front_pkg::PTR_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Back-pressure here refuses the data byte ack
  beat_fifo #(
    .WIDTH(eeprom_front_pkg::BEAT_W),
    .DEPTH(eeprom_front_pkg::FIFO_DEPTH)
  ) u_beat_fifo (
    .core_clk(core_clk),
    .srst(srst),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(push_beat),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(fifo_out)
  );

endmodule
`default_nettype wire

//--- eeprom_front_monitor.sv
// Concurrent checks on the memory front end ports
`timescale 1ns/100ps
`default_nettype none
module eeprom_front_monitor #(
  parameter int unsigned WRITE_CYCLE_CYCLES = 200
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Two-wire pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Straps
  input wire logic chip_select_strap_bit0,
  input wire logic chip_select_strap_bit1,
  input wire logic chip_select_strap_bit2,
  input wire logic write_protect,
  // Write path
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire eeprom_front_pkg::wr_beat_s wr_beat,
  input wire logic write_commit,
  input wire logic write_discard,
  // Read path
  input wire logic [eeprom_front_pkg::ADDR_W-1:0] rd_addr,
  input wire logic [eeprom_front_pkg::BYTE_W-1:0] rd_data,
  // Status
  input wire logic program_busy
);
  default clocking mon_cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // Counts only after commit, so a long drain wait is not charged
  logic timing_reg;
  logic [31:0] busy_cnt_reg;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      timing_reg <= 1'b0;
      busy_cnt_reg <= 32'h0;
    end else if (write_commit) begin
      timing_reg <= 1'b1;
      busy_cnt_reg <= 32'h0;
    end else if (timing_reg) begin
      timing_reg <= program_busy;
      busy_cnt_reg <= busy_cnt_reg + 32'h1;
    end
  end
  sequence busy_run;
    program_busy [*8];
  endsequence
  a_reset_quiet: assert property ($fell(srst) |-> !sda_oe && !program_busy &&
    rd_addr == 13'h0000) else $error("state not clear after reset");
  a_open_drain: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  a_oe_clock_low: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in))
    else $error("data pulled while clock high");
  a_oe_hold_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("data moved in clock high phase");
  a_busy_no_ack: assert property (program_busy |-> !$rose(sda_oe))
    else $error("acknowledge while busy");
  a_commit_busy: assert property (write_commit |=> busy_run)
    else $error("busy dropped after commit");
  a_busy_bound: assert property (busy_cnt_reg <= WRITE_CYCLE_CYCLES + 2)
    else $error("write cycle too long");
  a_commit_drained: assert property (write_commit |-> !wr_valid)
    else $error("commit with beats left");
  a_discard_idle: assert property (write_discard |=> !program_busy && !write_commit)
    else $error("write cycle after discard");
  a_beat_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_beat))
    else $error("beat lost before accept");
endmodule
`default_nettype wire

//--- two_wire_master.sv
// Behavioural two-wire bus master driving the serial clock
`timescale 1ns/100ps
`default_nettype none
module two_wire_master (
  // Clock
  input wire logic core_clk,
  // Bus lines
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Clock low 8, high 8: one 160 ns bit; clock rests high between frames
  task automatic bit_x(input logic b, output logic s);
    scl <= 1'b0;
    wt(6);
    sda_low <= !b;
    wt(2);
    scl <= 1'b1;
    wt(4);
    s = sda;
    wt(4);
  endtask
  task automatic start_cond();
    // The slave may still hold its ack low, so look at the wired line
    if (!(scl && sda)) begin
      scl <= 1'b0;
      wt(6);
      sda_low <= 1'b0;
      wt(2);
      scl <= 1'b1;
      wt(4);
    end
    sda_low <= 1'b1;
    wt(4);
  endtask
  task automatic stop_cond();
    scl <= 1'b0;
    wt(6);
    sda_low <= 1'b1;
    wt(2);
    scl <= 1'b1;
    wt(4);
    sda_low <= 1'b0;
    wt(8);
  endtask
  task automatic put_byte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(v[i], s);
    end
    bit_x(1'b1, s);
    ack = !s;
  endtask
  task automatic get_byte(input logic ack, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, s);
      v[i] = s;
    end
    bit_x(!ack, s);
  endtask
endmodule
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the two-wire memory front end
`timescale 1ns/100ps
`default_nettype none
module testbench;
  // Arbitrary type code for this bench
  localparam logic [3:0] TYPE_CODE = 4'h6;
  localparam logic [7:0] CTRL_W = {TYPE_CODE, 3'b010, 1'b0};
  typedef struct packed {
    logic [7:0] ctrl;
    logic [2:0] cs;
    logic ack;
  } row_s;
  row_s rows [7] = '{'{{TYPE_CODE, 3'b101, 1'b0}, 3'b101, 1'b1},
    '{{TYPE_CODE, 3'b101, 1'b1}, 3'b101, 1'b1},
    '{{TYPE_CODE ^ 4'h8, 3'b101, 1'b0}, 3'b101, 1'b0},
    '{{TYPE_CODE, 3'b100, 1'b0}, 3'b101, 1'b0},
    '{{TYPE_CODE, 3'b001, 1'b1}, 3'b101, 1'b0},
    '{{TYPE_CODE, 3'b111, 1'b0}, 3'b111, 1'b1},
    '{{TYPE_CODE, 3'b010, 1'b1}, 3'b010, 1'b1}};
  logic core_clk, srst, scl, sda_low, sda_out, sda_oe, write_protect;
  logic wr_valid, wr_ready, write_commit, write_discard, program_busy, a;
  wire logic sda_wire;
  logic [2:0] straps;
  eeprom_front_pkg::wr_beat_s wr_beat;
  logic [eeprom_front_pkg::ADDR_W-1:0] rd_addr;
  logic [7:0] rd_data, d;
  int fail_count, checks, commit_seen, discard_seen;
  // Pull-up on the data line: released means high
  assign sda_wire = !(sda_low || (sda_oe && !sda_out));
  assign rd_data = rd_addr[7:0] ^ 8'hA5;
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = !core_clk;
  end
  two_wire_master master (.core_clk(core_clk), .scl(scl), .sda_low(sda_low), .sda(sda_wire));
  eeprom_front #(.DEVICE_TYPE_CODE(TYPE_CODE), .WRITE_CYCLE_CYCLES(200)) uut (
    .core_clk(core_clk), .srst(srst), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
    .sda_oe(sda_oe), .chip_select_strap_bit0(straps[0]), .chip_select_strap_bit1(straps[1]),
    .chip_select_strap_bit2(straps[2]), .write_protect(write_protect), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_beat(wr_beat), .write_commit(write_commit),
    .write_discard(write_discard), .rd_addr(rd_addr), .rd_data(rd_data),
    .program_busy(program_busy));
  always @(negedge core_clk) begin
    if (write_commit === 1'b1) commit_seen++;
    if (write_discard === 1'b1) discard_seen++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic put(input logic [7:0] v, input logic exp);
    master.put_byte(v, a);
    chk(a, exp);
  endtask
  task automatic frame(input logic [7:0] ctrl, input logic exp);
    master.start_cond();
    put(ctrl, exp);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    @(negedge core_clk);
    while (program_busy !== 1'b0 && n < 2000) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 2000) begin
      fail_count++;
      stop_test();
    end
  endtask
  // Pops one beat at a time so the far side stalls between beats
  task automatic drain(input int cnt);
    int n;
    for (int i = 0; i < cnt; i++) begin
      n = 0;
      @(negedge core_clk);
      while (wr_valid !== 1'b1 && n < 50) begin
        @(negedge core_clk);
        n++;
      end
      if (n >= 50) begin
        fail_count++;
        stop_test();
      end
      chk(wr_beat, {8'h09, 5'(5'h1E + i), 8'(8'h40 + i)});
      @(posedge core_clk);
      wr_ready <= 1'b1;
      @(posedge core_clk);
      wr_ready <= 1'b0;
    end
  endtask
  initial begin
    srst = 1'b1;
    straps = 3'b101;
    write_protect = 1'b0;
    wr_ready = 1'b0;
    {fail_count, checks, commit_seen, discard_seen} = '0;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    master.wt(5);
    foreach (rows[i]) begin
      straps <= rows[i].cs;
      master.wt(8);
      frame(rows[i].ctrl, rows[i].ack);
      if (a === 1'b1 && rows[i].ctrl[0] === 1'b1) master.get_byte(1'b0, d);
      master.stop_cond();
    end
    master.start_cond();
    repeat (3) master.bit_x(1'b1, a);
    frame(CTRL_W, 1'b1);
    put(8'hFF, 1'b1);
    put(8'hFF, 1'b1);
    frame(CTRL_W | 8'h01, 1'b1);
    master.get_byte(1'b1, d);
    chk(d, 8'h5A);
    master.get_byte(1'b0, d);
    chk(d, 8'hA5);
    master.stop_cond();
    frame(CTRL_W, 1'b1);
    put(8'hE1, 1'b1);
    put(8'h3E, 1'b1);
    for (int i = 0; i < 17; i++) put(8'(8'h40 + i), i < 16);
    master.stop_cond();
    @(negedge core_clk);
    chk(program_busy, 1'b1);
    frame(CTRL_W, 1'b0);
    master.stop_cond();
    drain(16);
    wait_idle();
    chk(commit_seen, 1);
    chk(discard_seen, 0);
    write_protect <= 1'b1;
    wr_ready <= 1'b1;
    frame(CTRL_W, 1'b1);
    put(8'h00, 1'b1);
    put(8'h10, 1'b1);
    put(8'h77, 1'b1);
    master.stop_cond();
    write_protect <= 1'b0;
    master.wt(20);
    @(negedge core_clk);
    chk(program_busy, 1'b0);
    chk(discard_seen, 1);
    chk(commit_seen, 1);
    frame(CTRL_W, 1'b1);
    master.stop_cond();
    srst <= 1'b1;
    master.wt(2);
    srst <= 1'b0;
    @(negedge core_clk);
    chk(rd_addr, 13'h0000);
    stop_test();
  end
endmodule
bind eeprom_front eeprom_front_monitor #(.WRITE_CYCLE_CYCLES(WRITE_CYCLE_CYCLES)) mon (
  .core_clk(core_clk), .srst(srst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .chip_select_strap_bit0(chip_select_strap_bit0),
  .chip_select_strap_bit1(chip_select_strap_bit1),
  .chip_select_strap_bit2(chip_select_strap_bit2), .write_protect(write_protect),
  .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_beat(wr_beat), .write_commit(write_commit),
  .write_discard(write_discard), .rd_addr(rd_addr), .rd_data(rd_data),
  .program_busy(program_busy));
`default_nettype wire
